//--- design/mec_pkg.sv
package mec_pkg;
  // -------------------------------------------------------------
  // register indices (byte address is four times the index)
  // -------------------------------------------------------------
  localparam logic [7:0] IDX_PAGE_SEL = 8'h02;
  localparam logic [7:0] IDX_EMB_STATUS = 8'h12;
  localparam logic [7:0] IDX_PAGE_ACCESS = 8'h17;
  localparam logic [7:0] IDX_BATCH_CFG = 8'h44;
  localparam logic [7:0] IDX_EN_LOW = 8'h46;
  localparam logic [7:0] IDX_EN_HIGH = 8'h47;
  localparam logic [7:0] IDX_LC_LOW = 8'h48;
  localparam logic [7:0] IDX_LC_HIGH = 8'h49;
  localparam logic [7:0] IDX_LC_CLEAR = 8'h4a;
  localparam logic [7:0] IDX_OUTS1 = 8'h4c;
  localparam logic [7:0] IDX_OUTS2 = 8'h4d;
  localparam logic [7:0] IDX_PAGE_ADDR = 8'h60;
  localparam logic [7:0] IDX_PAGE_VALUE = 8'h61;

  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int BIT_LATCH_MODE = 7;
  localparam int BIT_PAGE_WRITE = 6;
  localparam int BIT_PAGE_READ = 5;
  localparam int BIT_STEP_BATCH = 6;
  localparam int BIT_WIPE_REQ = 0;
  localparam int BIT_WIPE_DONE = 1;
  localparam int BIT_TIMEOUT_FLAG = 7;
  localparam int PAGE_SEL_W = 4;
  localparam int EV_POS_X = 7;
  localparam int EV_NEG_X = 6;
  localparam int EV_POS_Y = 5;
  localparam int EV_NEG_Y = 4;
  localparam int EV_POS_Z = 3;
  localparam int EV_NEG_Z = 2;
  localparam int EV_POS_V = 1;
  localparam int EV_NEG_V = 0;

  // -------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  typedef struct packed {
    logic wr_stb;
    logic rd_stb;
    logic [3:0] sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mec_page_req_type;

  typedef struct packed {
    logic [15:0] value;
    logic done;
  } mec_lc_status_type;
endpackage

//--- design/mec_long_counter.sv
`timescale 1ns/10ps
module mec_long_counter (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic tick,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  input wire logic wipe_req,
  output mec_pkg::mec_lc_status_type status
);
  logic [15:0] cnt_q, cnt_d;
  logic done_q, done_d;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // -------------------------------------------------------------
  // counter and wipe handshake
  // -------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    done_d = done_q;
    if (wipe_req) begin
      // counter held at zero while the request stands
      cnt_d = mec_pkg::RST_COUNT;
      done_d = 1'b1;
    end else begin
      done_d = 1'b0;
      if (wr_low || wr_high) begin
        // host write wins over a tick in the same cycle
        if (wr_low) begin
          cnt_d[7:0] = wdata;
        end
        if (wr_high) begin
          cnt_d[15:8] = wdata;
        end
      end else if (tick) begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= mec_pkg::RST_COUNT;
      done_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign status.value = cnt_q;
  assign status.done = done_q;

  chk_wipe_zeroes_count: assert property (
    ce && wipe_req |=> cnt_q == 16'h0000 && done_q)
    else $error("wipe request did not zero the counter");
  chk_done_needs_req: assert property (
    $rose(done_q) |-> $past(wipe_req) && cnt_q == 16'h0000)
    else $error("wipe done rose without a request");
  chk_tick_increments: assert property (
    ce && tick && !wipe_req && !wr_low && !wr_high
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("tick did not advance the counter");
endmodule

//--- design/mec_event_capture.sv
`timescale 1ns/10ps
module mec_event_capture #(
  parameter int N_MACH = 2,
  parameter int FLAG_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [N_MACH-1:0] enable,
  input wire logic [N_MACH*FLAG_W-1:0] events,
  output logic [N_MACH*FLAG_W-1:0] flags
);
  logic [N_MACH*FLAG_W-1:0] flags_q, flags_d;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // -------------------------------------------------------------
  // per-machine flag capture; a disabled machine reports nothing
  // -------------------------------------------------------------
  genvar m;
  generate
    for (m = 0; m < N_MACH; m++) begin : g_mach
      always_comb begin
        flags_d[m*FLAG_W +: FLAG_W] = enable[m] ?
          events[m*FLAG_W +: FLAG_W] : '0;
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      flags_q <= '0;
    end else if (ce) begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

  chk_flags_follow: assert property (
    ce && enable[0] |=> flags_q[FLAG_W-1:0] == $past(events[FLAG_W-1:0]))
    else $error("machine one flags did not follow its events");
  chk_disabled_quiet: assert property (
    ce && !enable[N_MACH-1]
    |=> flags_q[N_MACH*FLAG_W-1 -: FLAG_W] == '0)
    else $error("disabled machine shows event flags");
endmodule

//--- design/mec_regs.sv
`timescale 1ns/10ps
// Summary of operation
// - latch-mode bit 7 chooses latched or unlatched embedded interrupt requests.
// - page writes pass only while page write-enable bit 6 is set.
// - page reads return data only while page read-enable bit 5 is set.
// - the page acted on is the 4-bit selector in page select register.
// - batching config bit 6 enables step counter values into the FIFO.
// - sixteen machine enables over two registers, all reset to disabled.
// - long counter is unsigned 16-bit, readable and writable by the host.
// - counter low byte at lower index, high byte next; both reset zero.
// - setting the wipe request bit zeroes the long counter.
// - read-only wipe-done bit sets once the counter has been zeroed.
// - machine one output register carries eight axis and vector event flags.
// - machine two output register at next index with the same flags.
// - a timeout event sets the timeout flag in the status register.
module mec_regs #(
  parameter int ADDR_W = 12,
  parameter int N_MACH = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lc_tick,
  input wire logic lc_timeout_evt,
  input wire logic [15:0] machine_events,
  input wire logic [7:0] page_rdata,
  output mec_pkg::mec_page_req_type page_req,
  output logic [N_MACH-1:0] machine_enable,
  output logic step_count_batching_enable,
  output logic embedded_irq_latch_mode,
  output logic emb_irq_req
);
  logic [7:0] idx;
  logic hit;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic xfer, wr_ok, status_rd;
  logic ack_q, ack_d;
  logic [31:0] prdata_q, prdata_d;
  logic [mec_pkg::PAGE_SEL_W-1:0] page_sel_q, page_sel_d;
  logic page_wr_en_q, page_wr_en_d;
  logic page_rd_en_q, page_rd_en_d;
  logic latch_mode_q, latch_mode_d;
  logic batch_q, batch_d;
  logic [N_MACH-1:0] en_q, en_d;
  logic wipe_req_q, wipe_req_d;
  logic timeout_flag_q, timeout_flag_d;
  logic [7:0] page_addr_q, page_addr_d;
  mec_pkg::mec_page_req_type page_req_q, page_req_d;
  mec_pkg::mec_lc_status_type lc_stat;
  logic [15:0] outs;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // -------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------
  assign idx = paddr[9:2];
  assign wbyte = pwdata[7:0];
  // no wait state while ce is high: prdata is captured in the cycle before
  assign pready = ack_q & ce;
  assign xfer = psel & penable & pready;
  assign pslverr = xfer & ~hit;
  assign wr_ok = xfer & pwrite & pstrb[0] & hit;
  assign status_rd = xfer & ~pwrite & (idx == mec_pkg::IDX_EMB_STATUS);

  always_comb begin
    rd_byte = mec_pkg::RST_BYTE;
    hit = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
    unique case (idx)
      mec_pkg::IDX_PAGE_SEL: begin
        rd_byte[mec_pkg::PAGE_SEL_W-1:0] = page_sel_q;
      end
      mec_pkg::IDX_EMB_STATUS: begin
        rd_byte[mec_pkg::BIT_TIMEOUT_FLAG] = timeout_flag_q;
      end
      mec_pkg::IDX_PAGE_ACCESS: begin
        rd_byte[mec_pkg::BIT_LATCH_MODE] = latch_mode_q;
        rd_byte[mec_pkg::BIT_PAGE_WRITE] = page_wr_en_q;
        rd_byte[mec_pkg::BIT_PAGE_READ] = page_rd_en_q;
      end
      mec_pkg::IDX_BATCH_CFG: begin
        rd_byte[mec_pkg::BIT_STEP_BATCH] = batch_q;
      end
      mec_pkg::IDX_EN_LOW: rd_byte = en_q[7:0];
      mec_pkg::IDX_EN_HIGH: rd_byte = en_q[15:8];
      mec_pkg::IDX_LC_LOW: rd_byte = lc_stat.value[7:0];
      mec_pkg::IDX_LC_HIGH: rd_byte = lc_stat.value[15:8];
      mec_pkg::IDX_LC_CLEAR: begin
        rd_byte[mec_pkg::BIT_WIPE_REQ] = wipe_req_q;
        rd_byte[mec_pkg::BIT_WIPE_DONE] = lc_stat.done;
      end
      mec_pkg::IDX_OUTS1: rd_byte = outs[7:0];
      mec_pkg::IDX_OUTS2: rd_byte = outs[15:8];
      mec_pkg::IDX_PAGE_ADDR: rd_byte = page_addr_q;
      mec_pkg::IDX_PAGE_VALUE: begin
        // refused page reads return zero, not stale data
        rd_byte = page_rd_en_q ? page_rdata : mec_pkg::RST_BYTE;
      end
      default: hit = 1'b0;
    endcase
  end

  // -------------------------------------------------------------
  // register next values
  // -------------------------------------------------------------
  always_comb begin
    ack_d = psel & ~(penable & ack_q);
    prdata_d = prdata_q;
    if (psel && !(penable && ack_q)) begin
      prdata_d = hit ? {24'h000000, rd_byte} : 32'h00000000;
    end
    page_sel_d = page_sel_q;
    page_wr_en_d = page_wr_en_q;
    page_rd_en_d = page_rd_en_q;
    latch_mode_d = latch_mode_q;
    batch_d = batch_q;
    en_d = en_q;
    wipe_req_d = wipe_req_q;
    page_addr_d = page_addr_q;
    page_req_d = '0;
    page_req_d.sel = page_sel_q;
    page_req_d.addr = page_addr_q;
    page_req_d.wdata = page_req_q.wdata;
    if (wr_ok) begin
      // only defined bits are stored; reserved bits stay zero
      unique case (idx)
        mec_pkg::IDX_PAGE_SEL: begin
          page_sel_d = wbyte[mec_pkg::PAGE_SEL_W-1:0];
        end
        mec_pkg::IDX_PAGE_ACCESS: begin
          latch_mode_d = wbyte[mec_pkg::BIT_LATCH_MODE];
          page_wr_en_d = wbyte[mec_pkg::BIT_PAGE_WRITE];
          page_rd_en_d = wbyte[mec_pkg::BIT_PAGE_READ];
        end
        mec_pkg::IDX_BATCH_CFG: begin
          batch_d = wbyte[mec_pkg::BIT_STEP_BATCH];
        end
        mec_pkg::IDX_EN_LOW: en_d[7:0] = wbyte;
        mec_pkg::IDX_EN_HIGH: en_d[15:8] = wbyte;
        mec_pkg::IDX_LC_CLEAR: begin
          wipe_req_d = wbyte[mec_pkg::BIT_WIPE_REQ];
        end
        mec_pkg::IDX_PAGE_ADDR: page_addr_d = wbyte;
        mec_pkg::IDX_PAGE_VALUE: begin
          page_req_d.wr_stb = page_wr_en_q;
          page_req_d.wdata = wbyte;
        end
        default: ;
      endcase
    end
    if (xfer && !pwrite && idx == mec_pkg::IDX_PAGE_VALUE) begin
      page_req_d.rd_stb = page_rd_en_q;
    end
  end

  // -------------------------------------------------------------
  // timeout flag: sticky until status read in latched mode
  // -------------------------------------------------------------
  always_comb begin
    if (latch_mode_q) begin
      // a new event in the clearing read's cycle is kept
      timeout_flag_d = lc_timeout_evt |
        (timeout_flag_q & ~status_rd);
    end else begin
      timeout_flag_d = lc_timeout_evt;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      prdata_q <= 32'h00000000;
      page_sel_q <= '0;
      page_wr_en_q <= 1'b0;
      page_rd_en_q <= 1'b0;
      latch_mode_q <= 1'b0;
      batch_q <= 1'b0;
      en_q <= '0;
      wipe_req_q <= 1'b0;
      timeout_flag_q <= 1'b0;
      page_addr_q <= mec_pkg::RST_BYTE;
      page_req_q <= '0;
    end else if (ce) begin
      ack_q <= ack_d;
      prdata_q <= prdata_d;
      page_sel_q <= page_sel_d;
      page_wr_en_q <= page_wr_en_d;
      page_rd_en_q <= page_rd_en_d;
      latch_mode_q <= latch_mode_d;
      batch_q <= batch_d;
      en_q <= en_d;
      wipe_req_q <= wipe_req_d;
      timeout_flag_q <= timeout_flag_d;
      page_addr_q <= page_addr_d;
      page_req_q <= page_req_d;
    end
  end

  // -------------------------------------------------------------
  // sub-blocks and outputs
  // -------------------------------------------------------------
  mec_long_counter u_counter (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .tick(lc_tick),
    .wr_low(wr_ok && idx == mec_pkg::IDX_LC_LOW),
    .wr_high(wr_ok && idx == mec_pkg::IDX_LC_HIGH),
    .wdata(wbyte),
    .wipe_req(wipe_req_q),
    .status(lc_stat)
  );

  mec_event_capture #(.N_MACH(2), .FLAG_W(8)) u_events (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .enable(en_q[1:0]),
    .events(machine_events),
    .flags(outs)
  );

  assign prdata = prdata_q;
  assign page_req = page_req_q;
  assign machine_enable = en_q;
  assign step_count_batching_enable = batch_q;
  assign embedded_irq_latch_mode = latch_mode_q;
  assign emb_irq_req = timeout_flag_q;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  chk_page_wr_gate: assert property (
    page_req_q.wr_stb |-> $past(page_wr_en_q) && $past(wr_ok))
    else $error("page write passed while writes disabled");
  chk_page_rd_zero: assert property (
    xfer && !pwrite && idx == mec_pkg::IDX_PAGE_VALUE && !page_rd_en_q
    |-> prdata == 32'h00000000)
    else $error("page read returned data while reads disabled");
  chk_latch_holds: assert property (
    ce && latch_mode_q && timeout_flag_q && !status_rd |=> timeout_flag_q)
    else $error("latched timeout flag dropped without a read");
  chk_unlatched_follow: assert property (
    ce && !latch_mode_q |=> timeout_flag_q == $past(lc_timeout_evt))
    else $error("unlatched flag does not follow the event");
  chk_timeout_sets: assert property (
    ce && lc_timeout_evt |=> timeout_flag_q ##0 emb_irq_req)
    else $error("timeout event did not set the flag");
  chk_enable_high_write: assert property (
    wr_ok && idx == mec_pkg::IDX_EN_HIGH
    |=> machine_enable[15:8] == $past(pwdata[7:0]))
    else $error("machine enable high byte not stored");
  chk_batch_write: assert property (
    wr_ok && idx == mec_pkg::IDX_BATCH_CFG
    |=> step_count_batching_enable == $past(pwdata[6]))
    else $error("batching enable not stored");
  // measured from the setup cycle only; the access cycle ends the answer
  chk_ready_bound: assert property (
    psel && !penable && ce ##1 ce
    |-> ##[0:1] pready)
    else $error("apb answer later than one wait state");
  chk_reset_state: assert property (
    disable iff (1'b0) !nrst |=> machine_enable == '0 &&
    lc_stat.value == 16'h0000 && !emb_irq_req)
    else $error("state not cleared by reset");
  chk_page_rd_gate: assert property (
    page_req_q.rd_stb |-> $past(page_rd_en_q))
    else $error("page read strobe while reads disabled");
  // the request carries the selector as it stood one edge before
  chk_page_sel_carry: assert property (
    ce |=> page_req.sel == $past(page_sel_q))
    else $error("page request does not carry the selector");
  chk_page_wr_data: assert property (
    $past(ce) && page_req_q.wr_stb
    |-> page_req_q.wdata == $past(wbyte))
    else $error("page write carries the wrong data");
  chk_enable_low_write: assert property (
    wr_ok && idx == mec_pkg::IDX_EN_LOW
    |=> machine_enable[7:0] == $past(pwdata[7:0]))
    else $error("machine enable low byte not stored");
  chk_latch_write: assert property (
    wr_ok && idx == mec_pkg::IDX_PAGE_ACCESS
    |=> embedded_irq_latch_mode == $past(pwdata[mec_pkg::BIT_LATCH_MODE]))
    else $error("latch mode bit not stored");
  chk_status_clears: assert property (
    latch_mode_q && status_rd && !lc_timeout_evt |=> !timeout_flag_q)
    else $error("latched flag survived its status read");
  // a low enable must hold state, or a stalled bus would lose writes
  chk_ce_freezes: assert property (
    !ce |=> $stable(en_q) && $stable(timeout_flag_q)
    && $stable(page_sel_q))
    else $error("state changed while the clock enable was low");
endmodule

//--- test/mec_regs_tb.sv
`timescale 1ns/10ps
module mec_regs_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk, nrst, ce, psel, penable, pwrite;
  logic lc_tick, lc_timeout_evt, err;
  logic pready, pslverr, emb_irq_req;
  logic step_count_batching_enable, embedded_irq_latch_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] pstrb;
  logic [15:0] machine_events, machine_enable;
  logic [7:0] page_rdata;
  mec_pkg::mec_page_req_type page_req, last_req;
  int bad_count, checks_done, n_wr, n_rd, i, n;
  logic [7:0] rst_idx [10];

  mec_regs #(.ADDR_W(12), .N_MACH(16)) i_dut (
    .clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lc_tick(lc_tick), .lc_timeout_evt(lc_timeout_evt),
    .machine_events(machine_events), .page_rdata(page_rdata),
    .page_req(page_req), .machine_enable(machine_enable),
    .step_count_batching_enable(step_count_batching_enable),
    .embedded_irq_latch_mode(embedded_irq_latch_mode),
    .emb_irq_req(emb_irq_req)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // page strobes are one-cycle pulses, so count them as they pass
  always @(posedge clk) begin
    if (page_req.wr_stb === 1'b1) begin
      n_wr++;
      last_req = page_req;
    end
    if (page_req.rd_stb === 1'b1) n_rd++;
  end

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // entered just after a rising edge; leaves just after one
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      bad_count++;
      $display("CHECK FAILED at %0t: no ready", $time);
    end
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so no bus signal is driven twice in one step
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd_exp(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rv, {24'h000000, exp});
    chk(err, 1'b0);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf; lc_tick = 1'b0;
    lc_timeout_evt = 1'b0; machine_events = 16'h0000;
    page_rdata = 8'h6b; bad_count = 0; checks_done = 0; n_wr = 0; n_rd = 0;
    rst_idx = '{mec_pkg::IDX_PAGE_ACCESS, mec_pkg::IDX_BATCH_CFG,
      mec_pkg::IDX_EN_LOW, mec_pkg::IDX_EN_HIGH, mec_pkg::IDX_LC_LOW,
      mec_pkg::IDX_LC_HIGH, mec_pkg::IDX_LC_CLEAR, mec_pkg::IDX_OUTS1,
      mec_pkg::IDX_OUTS2, mec_pkg::IDX_EMB_STATUS};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 10; i++) begin
      rd_exp(rst_idx[i], 8'h00);
    end
    chk({machine_enable, embedded_irq_latch_mode}, 17'h0);
    // control bits, reserved positions kept zero
    wr(mec_pkg::IDX_PAGE_ACCESS, 8'he0);
    rd_exp(mec_pkg::IDX_PAGE_ACCESS, 8'he0);
    chk(embedded_irq_latch_mode, 1'b1);
    wr(mec_pkg::IDX_BATCH_CFG, 8'h40);
    rd_exp(mec_pkg::IDX_BATCH_CFG, 8'h40);
    chk(step_count_batching_enable, 1'b1);
    // walk a single enable across all sixteen machines
    for (i = 0; i < 16; i++) begin
      wr(mec_pkg::IDX_EN_LOW, 8'(16'h0001 << i));
      wr(mec_pkg::IDX_EN_HIGH, 8'((16'h0001 << i) >> 8));
      chk(machine_enable, 16'h0001 << i);
    end
    // long counter bytes, ticking and wrap
    wr(mec_pkg::IDX_LC_LOW, 8'h34);
    wr(mec_pkg::IDX_LC_HIGH, 8'h12);
    rd_exp(mec_pkg::IDX_LC_HIGH, 8'h12);
    lc_tick <= 1'b1;
    repeat (3) @(posedge clk);
    lc_tick <= 1'b0;
    rd_exp(mec_pkg::IDX_LC_LOW, 8'h37);
    wr(mec_pkg::IDX_LC_LOW, 8'hff);
    wr(mec_pkg::IDX_LC_HIGH, 8'hff);
    lc_tick <= 1'b1;
    @(posedge clk);
    lc_tick <= 1'b0;
    rd_exp(mec_pkg::IDX_LC_LOW, 8'h00);
    rd_exp(mec_pkg::IDX_LC_HIGH, 8'h00);
    // a low clock enable must not count ticks
    ce <= 1'b0;
    lc_tick <= 1'b1;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    lc_tick <= 1'b0;
    rd_exp(mec_pkg::IDX_LC_LOW, 8'h00);
    // wipe while the counter keeps ticking
    wr(mec_pkg::IDX_LC_LOW, 8'h5a);
    lc_tick <= 1'b1;
    wr(mec_pkg::IDX_LC_CLEAR, 8'h01);
    n = 0;
    do begin
      apb(1'b0, mec_pkg::IDX_LC_CLEAR, 8'h00);
      n++;
    end while (rv[mec_pkg::BIT_WIPE_DONE] !== 1'b1 && n < 10);
    chk(rv, 8'h03);
    rd_exp(mec_pkg::IDX_LC_LOW, 8'h00);
    rd_exp(mec_pkg::IDX_LC_HIGH, 8'h00);
    lc_tick <= 1'b0;
    wr(mec_pkg::IDX_LC_CLEAR, 8'h00);
    @(posedge clk);
    rd_exp(mec_pkg::IDX_LC_CLEAR, 8'h00);
    // event flags of machines one and two
    wr(mec_pkg::IDX_EN_LOW, 8'h03);
    wr(mec_pkg::IDX_EN_HIGH, 8'h00);
    for (i = 0; i < 8; i++) begin
      machine_events <= {8'h01 << i, 8'h80 >> i};
      repeat (2) @(posedge clk);
      rd_exp(mec_pkg::IDX_OUTS1, 8'h80 >> i);
      rd_exp(mec_pkg::IDX_OUTS2, 8'h01 << i);
    end
    wr(mec_pkg::IDX_OUTS1, 8'h00);
    rd_exp(mec_pkg::IDX_OUTS1, 8'h01);
    wr(mec_pkg::IDX_EN_LOW, 8'h01);
    rd_exp(mec_pkg::IDX_OUTS2, 8'h00);
    // page access gated by the enable bits
    wr(mec_pkg::IDX_PAGE_SEL, 8'h05);
    wr(mec_pkg::IDX_PAGE_ADDR, 8'h21);
    wr(mec_pkg::IDX_PAGE_ACCESS, 8'h00);
    wr(mec_pkg::IDX_PAGE_VALUE, 8'h77);
    rd_exp(mec_pkg::IDX_PAGE_VALUE, 8'h00);
    repeat (2) @(posedge clk);
    chk(n_wr, 0);
    chk(n_rd, 0);
    wr(mec_pkg::IDX_PAGE_ACCESS, 8'h40);
    wr(mec_pkg::IDX_PAGE_VALUE, 8'h9c);
    repeat (2) @(posedge clk);
    chk(n_wr, 1);
    chk(last_req, {1'b1, 1'b0, 4'h5, 8'h21, 8'h9c});
    wr(mec_pkg::IDX_PAGE_ACCESS, 8'h20);
    rd_exp(mec_pkg::IDX_PAGE_VALUE, 8'h6b);
    repeat (2) @(posedge clk);
    chk(n_wr, 1);
    chk(n_rd, 1);
    // timeout flag, latched then unlatched
    wr(mec_pkg::IDX_PAGE_ACCESS, 8'h80);
    lc_timeout_evt <= 1'b1;
    @(posedge clk);
    lc_timeout_evt <= 1'b0;
    repeat (3) @(posedge clk);
    chk(emb_irq_req, 1'b1);
    rd_exp(mec_pkg::IDX_EMB_STATUS, 8'h80);
    rd_exp(mec_pkg::IDX_EMB_STATUS, 8'h00);
    wr(mec_pkg::IDX_PAGE_ACCESS, 8'h00);
    lc_timeout_evt <= 1'b1;
    repeat (2) @(posedge clk);
    rd_exp(mec_pkg::IDX_EMB_STATUS, 8'h80);
    rd_exp(mec_pkg::IDX_EMB_STATUS, 8'h80);
    lc_timeout_evt <= 1'b0;
    repeat (2) @(posedge clk);
    rd_exp(mec_pkg::IDX_EMB_STATUS, 8'h00);
    chk(emb_irq_req, 1'b0);
    // unmapped index answers with an error and reads zero
    wr(8'h30, 8'h55);
    chk(err, 1'b1);
    apb(1'b0, 8'h30, 8'h00);
    chk({err, rv[7:0]}, 9'h100);
    // a second reset in mid-run clears stored state
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({machine_enable, step_count_batching_enable}, 17'h0);
    rd_exp(mec_pkg::IDX_LC_CLEAR, 8'h00);
    print_verdict();
  end
endmodule
